// [bench/fvr_readback_regs_properties.sv]
// Purpose: apb timing and refusal checks of the readback bank
// Assumes: zero-wait slave, pready one cycle after setup
// Notes:   bound to fvr_readback_regs below
`timescale 1ns/1ns
`include "fvr_map.vh"
module fvr_props (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [15:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr
);
	wire setup = psel && !penable;
	wire smp   = paddr[1:0] == 2'b00 && paddr[15:2] inside {`FVR_IDX_PHA_V, `FVR_IDX_PHB_V,
		`FVR_IDX_PHC_V, `FVR_IDX_SIN, `FVR_IDX_COS, `FVR_IDX_STATIONARY_ALPHA_CURRENT};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// access phase timing
	AST_SETUP_READY: assert property (setup |=> pready)
		else $error("no ready after setup");
	AST_READY_SOURCE: assert property (pready |-> $past(setup))
		else $error("stray ready");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready too long");
	AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h00000000)
		else $error("idle data");
	AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h00000000)
		else $error("err data");
	// ==========================================================
	// sample words are read-only; misaligned addresses are refused
	AST_RO_WRITE: assert property (setup && pwrite && smp |=> pslverr)
		else $error("write taken");
	AST_RD_OK: assert property (setup && !pwrite && smp |=> !pslverr)
		else $error("read refused");
	AST_MISALIGN: assert property (setup && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("misalign ok");
endmodule
bind fvr_readback_regs fvr_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

// [bench/testbench.sv]
// Purpose: self-checking bench of the readback bank
// Assumes: apb master by nonblocking drive after rising edge
// Notes:   update port driven as the control algorithm would
`timescale 1ns/1ns
`include "fvr_map.vh"
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, upd_valid, pready, pslverr, er;
	logic [15:0] paddr;
	logic [31:0] pwdata, upd_data, prdata, rd;
	logic [2:0]  upd_sel;
	int          n_fail, compares;
	localparam logic [15:0] SA [6] = '{{`FVR_IDX_PHA_V, 2'b00}, {`FVR_IDX_PHB_V, 2'b00},
		{`FVR_IDX_PHC_V, 2'b00}, {`FVR_IDX_SIN, 2'b00}, {`FVR_IDX_COS, 2'b00},
		{`FVR_IDX_STATIONARY_ALPHA_CURRENT, 2'b00}};
	localparam logic [15:0] CTRL = {`FVR_IDX_CTRL, 2'b00};
	localparam logic [15:0] STAT = {`FVR_IDX_STAT, 2'b00};
	localparam logic [15:0] CNT  = {`FVR_IDX_UPD_CNT, 2'b00};
	// signs alternate so the status sign field shows 1,0,1,0,1,0
	localparam logic [31:0] VAL [6] = '{32'h80000001, 32'h7fffffff, 32'hf8000000,
		32'h08000000, 32'hfc000000, 32'h00000001};
	fvr_readback_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .upd_valid(upd_valid), .upd_sel(upd_sel), .upd_data(upd_data));
	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees ready
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(nm, e, rd);
		chk("slverr", 32'h00000000, {31'h0, er});
	endtask
	task automatic upd(input logic [2:0] s, input logic [31:0] d);
		@(posedge pclk);
		upd_valid <= 1'b1;
		upd_sel <= s;
		upd_data <= d;
		@(posedge pclk);
		upd_valid <= 1'b0;
	endtask
	task automatic results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset;
		for (int i = 0; i < 6; i++) rdchk("reset word", SA[i], 32'h00000000);
		$display("test reset done");
	endtask
	task automatic t_values;
		logic [31:0] e;
		e = 32'h00150000;
		for (int i = 0; i < 6; i++) begin
			upd(i[2:0], VAL[i]);
			rdchk("sample", SA[i], VAL[i]);
		end
		rdchk("status", STAT, e);
		rdchk("count", CNT, 32'h00000006);
		$display("test values done");
	endtask
	task automatic t_refuse;
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, SA[i], 32'h5a5a5a5a);
			chk("wr slverr", 32'h00000001, {31'h0, er});
			rdchk("kept", SA[i], VAL[i]);
		end
		apb(1'b0, 16'h0ffc, 32'h00000000);
		chk("unmapped", 32'h00000001, {31'h0, er});
		chk("err data", 32'h00000000, rd);
		apb(1'b0, SA[0] | 16'h0002, 32'h00000000);
		chk("misaligned", 32'h00000001, {31'h0, er});
		$display("test refuse done");
	endtask
	task automatic t_sel;
		upd(3'h6, 32'h11111111);
		upd(3'h7, 32'h22222222);
		rdchk("count", CNT, 32'h00000006);
		rdchk("sel ignored", SA[0], VAL[0]);
		apb(1'b1, CNT, 32'h00000000);
		rdchk("count clr", CNT, 32'h00000000);
		$display("test sel done");
	endtask
	task automatic t_overrun;
		// both values negative so the sign field stays as left by t_values
		upd(3'h2, 32'hf0000010);
		upd(3'h2, VAL[2]);
		rdchk("ovr status", STAT, 32'h00150404);
		apb(1'b1, STAT, 32'h00000400);
		chk("stat wr slverr", 32'h00000000, {31'h0, er});
		rdchk("ovr cleared", STAT, 32'h00150004);
		rdchk("last value", SA[2], VAL[2]);
		rdchk("fresh cleared", STAT, 32'h00150000);
		rdchk("count two", CNT, 32'h00000002);
		$display("test overrun done");
	endtask
	task automatic t_freeze;
		apb(1'b1, CTRL, 32'h00000001);
		upd(3'h3, 32'h01234567);
		rdchk("ctrl", CTRL, 32'h00000001);
		rdchk("status", STAT, 32'h01150008);
		rdchk("frozen", SA[3], VAL[3]);
		rdchk("status seen", STAT, 32'h01150000);
		apb(1'b1, CTRL, 32'h00000000);
		rdchk("live", SA[3], 32'h01234567);
		$display("test freeze done");
	endtask
	task automatic t_midreset;
		upd(3'h5, 32'hffffffff);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rdchk("rereset", SA[i], 32'h00000000);
		rdchk("rereset count", CNT, 32'h00000000);
		rdchk("rereset status", STAT, 32'h00000000);
		$display("test midreset done");
	endtask
	// ==========================================================
	// clock, sequence, watchdog
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, upd_valid} = 5'h00;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
		upd_data = 32'h00000000;
		upd_sel = 3'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_values;
		t_refuse;
		t_sel;
		t_overrun;
		t_freeze;
		t_midreset;
		results;
	end
	initial begin
		// whole run needs well under 400 cycles
		repeat (3000) @(posedge pclk);
		n_fail++;
		results;
	end
endmodule

// [core/fvr_addr_decode.v]
// Purpose: APB address to one-hot register select
// Assumes: paddr stable through setup and access
// Notes:   misaligned or unlisted addresses give mapped low
`timescale 1ns/1ns
`include "fvr_map.vh"

module fvr_addr_decode (
	input  wire [15:0]             paddr,
	output reg  [`FVR_HIT_W-1:0]   hit,
	output wire                    mapped
);

	// ==========================================================
	// decode
	always @* begin
		hit = {`FVR_HIT_W{1'b0}};
		if (paddr[1:0] == 2'h0) begin
			case (paddr[15:2])
				`FVR_IDX_PHA_V:   hit[`FVR_HIT_PHA_V]   = 1'b1;
				`FVR_IDX_PHB_V:   hit[`FVR_HIT_PHB_V]   = 1'b1;
				`FVR_IDX_PHC_V:   hit[`FVR_HIT_PHC_V]   = 1'b1;
				`FVR_IDX_SIN:     hit[`FVR_HIT_SIN]     = 1'b1;
				`FVR_IDX_COS:     hit[`FVR_HIT_COS]     = 1'b1;
				`FVR_IDX_STATIONARY_ALPHA_CURRENT:  hit[`FVR_HIT_STATIONARY_ALPHA_CURRENT]  = 1'b1;
				`FVR_IDX_CTRL:    hit[`FVR_HIT_CTRL]    = 1'b1;
				`FVR_IDX_STAT:    hit[`FVR_HIT_STAT]    = 1'b1;
				`FVR_IDX_UPD_CNT: hit[`FVR_HIT_UPD_CNT] = 1'b1;
				default:          hit = {`FVR_HIT_W{1'b0}};
			endcase
		end
	end

	assign mapped = |hit;

endmodule

// [core/fvr_readback_regs.v]
// Purpose: APB read-only bank of control algorithm variables
// Assumes: update strobe inputs synchronous to pclk
// Notes:   one access-phase cycle per transfer; pready comes from a flop
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`include "fvr_map.vh"

module fvr_readback_regs (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [15:0] paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        upd_valid,
	input  wire [2:0]  upd_sel,
	input  wire [31:0] upd_data
);

	localparam NS = `FVR_NUM_SAMPLE;

	// ==========================================================
	// apb handshake state
	reg  [31:0]           prdata_ff;
	reg                   pready_ff;
	reg                   pslverr_ff;
	reg  [31:0]           nxt_prdata;
	reg                   nxt_pslverr;
	wire                  nxt_pready;

	// ==========================================================
	// software visible control and status
	reg                   freeze_ff;
	reg  [NS-1:0]         overrun_ff;
	reg  [15:0]           upd_cnt_ff;
	reg  [15:0]           nxt_upd_cnt;
	wire                  nxt_freeze;
	wire [NS-1:0]         nxt_overrun;

	// ==========================================================
	// decode and strobes
	wire [`FVR_HIT_W-1:0] hit;
	wire                  mapped;
	wire                  setup_ph;
	wire                  done_ph;
	wire                  rd_done;
	wire                  wr_done;
	wire                  wr_to_ro;
	wire                  ctrl_wr;
	wire                  stat_wr;
	wire                  cnt_wr;
	wire                  freeze_take;
	wire                  upd_any;

	// ==========================================================
	// per-sample signals, flattened
	wire [32*NS-1:0]      word_bus;
	wire [NS-1:0]         fresh_vec;
	wire [NS-1:0]         ovr_evt_vec;
	wire [NS-1:0]         sign_vec;
	wire [NS-1:0]         upd_en_vec;
	wire [NS-1:0]         rd_clr_vec;
	wire [31:0]           stat_word;
	wire [31:0]           ctrl_word;
	wire [31:0]           cnt_word;

	integer k;

	// ==========================================================
	// address decode
	fvr_addr_decode u_decode (
		.paddr  (paddr),
		.hit    (hit),
		.mapped (mapped)
	);

	// ==========================================================
	// apb phases
	// pready is a flop, so the slave answers in the first access cycle
	// and every transfer is exactly setup plus one access cycle
	assign setup_ph   = psel & ~penable;
	assign done_ph    = psel & penable & pready_ff;
	assign nxt_pready = setup_ph;

	// sample words are read-only; a write there is an error with no effect
	assign wr_to_ro   = pwrite & (|hit[NS-1:0]);

	assign rd_done    = done_ph & ~pwrite & ~pslverr_ff;
	assign wr_done    = done_ph &  pwrite & ~pslverr_ff;
	assign ctrl_wr    = wr_done & hit[`FVR_HIT_CTRL];
	assign stat_wr    = wr_done & hit[`FVR_HIT_STAT];
	assign cnt_wr     = wr_done & hit[`FVR_HIT_UPD_CNT];

	// ==========================================================
	// freeze control
	// snapshot is taken only on the rising edge of the freeze bit so a
	// repeated write of one does not refresh a half-read set of words
	assign nxt_freeze  = ctrl_wr ? pwdata[`FVR_CTRL_FREEZE] : freeze_ff;
	assign freeze_take = ctrl_wr & pwdata[`FVR_CTRL_FREEZE] & ~freeze_ff;

	// ==========================================================
	// sample bank
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi = gi + 1) begin : g_sample
			// widened select keeps the compare at the genvar's own width
			assign upd_en_vec[gi] = upd_valid & ({29'h00000000, upd_sel} == gi);
			// a completed read of the word marks it as seen
			assign rd_clr_vec[gi] = rd_done & hit[gi];

			fvr_sample_reg u_sample (
				.pclk        (pclk),
				.presetn     (presetn),
				.upd_en      (upd_en_vec[gi]),
				.upd_data    (upd_data),
				.freeze_take (freeze_take),
				.frozen      (freeze_ff),
				.rd_clear    (rd_clr_vec[gi]),
				.read_word   (word_bus[32*gi +: 32]),
				.fresh       (fresh_vec[gi]),
				.overrun_evt (ovr_evt_vec[gi]),
				.sign        (sign_vec[gi])
			);
		end
	endgenerate

	// ==========================================================
	// overrun flags
	// write one to clear; a new overrun in the same cycle wins
	assign nxt_overrun = (overrun_ff & ~({NS{stat_wr}} & pwdata[`FVR_STAT_OVR_LO +: NS]))
	                   | ovr_evt_vec;

	// ==========================================================
	// update counter
	// selects above the bank are ignored and not counted
	assign upd_any = |upd_en_vec;

	always @* begin
		nxt_upd_cnt = upd_cnt_ff;
		if (cnt_wr) begin
			nxt_upd_cnt = upd_any ? `FVR_CNT_ONE : `FVR_CNT_RST;
		end else if (upd_any) begin
			nxt_upd_cnt = upd_cnt_ff + `FVR_CNT_ONE;
		end
	end

	// ==========================================================
	// readback words of the own registers
	assign ctrl_word = {31'h00000000, freeze_ff};
	assign cnt_word  = {16'h0000, upd_cnt_ff};
	assign stat_word = {7'h00, freeze_ff,
	                    2'h0, sign_vec,
	                    2'h0, overrun_ff,
	                    2'h0, fresh_vec};

	// ==========================================================
	// read mux, captured in the setup cycle
	// capturing at setup keeps prdata a flop output; an update landing in
	// the access cycle shows on the next read and keeps its fresh flag
	always @* begin
		nxt_prdata  = `FVR_WORD_ZERO;
		nxt_pslverr = 1'b0;
		if (!mapped || wr_to_ro) begin
			nxt_pslverr = 1'b1;
		end else if (!pwrite) begin
			for (k = 0; k < NS; k = k + 1) begin
				if (hit[k]) begin
					nxt_prdata = word_bus[32*k +: 32];
				end
			end
			if (hit[`FVR_HIT_CTRL]) begin
				nxt_prdata = ctrl_word;
			end
			if (hit[`FVR_HIT_STAT]) begin
				nxt_prdata = stat_word;
			end
			if (hit[`FVR_HIT_UPD_CNT]) begin
				nxt_prdata = cnt_word;
			end
		end
	end

	// ==========================================================
	// apb output flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= `FVR_WORD_ZERO;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= nxt_pready;
			if (setup_ph) begin
				prdata_ff  <= nxt_prdata;
				pslverr_ff <= nxt_pslverr;
			end else if (done_ph) begin
				// drop back to idle values once the transfer closes
				prdata_ff  <= `FVR_WORD_ZERO;
				pslverr_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// control and status flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freeze_ff  <= 1'b0;
			overrun_ff <= {NS{1'b0}};
			upd_cnt_ff <= `FVR_CNT_RST;
		end else begin
			freeze_ff  <= nxt_freeze;
			overrun_ff <= nxt_overrun;
			upd_cnt_ff <= nxt_upd_cnt;
		end
	end

	// ==========================================================
	// outputs
	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

endmodule

// [core/fvr_sample_reg.v]
// Purpose: one signed 27-bit-fraction sample word with snapshot and fresh flag
// Assumes: upd_en is a one-cycle strobe from the control algorithm
// Notes:   snapshot keeps multi-word reads coherent while frozen
`timescale 1ns/1ns
`include "fvr_map.vh"

module fvr_sample_reg (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        upd_en,
	input  wire [31:0] upd_data,
	input  wire        freeze_take,
	input  wire        frozen,
	input  wire        rd_clear,
	output wire [31:0] read_word,
	output wire        fresh,
	output wire        overrun_evt,
	output wire        sign
);

	reg  [31:0] live_ff;
	reg  [31:0] snap_ff;
	reg         fresh_ff;
	wire        nxt_fresh;

	// ==========================================================
	// storage
	// set wins over a read clear in the same cycle
	assign nxt_fresh = upd_en | (fresh_ff & ~rd_clear);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_ff  <= `FVR_SAMPLE_RST;
			snap_ff  <= `FVR_SAMPLE_RST;
			fresh_ff <= 1'b0;
		end else begin
			if (upd_en) begin
				live_ff <= upd_data;
			end
			if (freeze_take) begin
				snap_ff <= live_ff;
			end
			fresh_ff <= nxt_fresh;
		end
	end

	// ==========================================================
	// readback
	assign read_word   = frozen ? snap_ff : live_ff;
	assign fresh       = fresh_ff;
	// an unread value being overwritten; a read in the same cycle saw it
	assign overrun_evt = upd_en & fresh_ff & ~rd_clear;
	assign sign        = live_ff[31];

endmodule

// [inc/fvr_map.vh]
// Purpose: constants for the algorithm variable readback bank
// Assumes: APB, 32-bit data, word index = byte address / 4
// Notes:   printed locations are word indices; byte address is four times the index
`ifndef FVR_MAP_VH
`define FVR_MAP_VH

// ==========================================================
// word indices (paddr[15:2])
`define FVR_IDX_PHA_V       14'h047e
`define FVR_IDX_PHB_V       14'h0480
`define FVR_IDX_PHC_V       14'h0482
`define FVR_IDX_SIN         14'h04ba
`define FVR_IDX_COS         14'h04bc
`define FVR_IDX_STATIONARY_ALPHA_CURRENT      14'h04d4
`define FVR_IDX_CTRL        14'h0500
`define FVR_IDX_STAT        14'h0501
`define FVR_IDX_UPD_CNT     14'h0502

// ==========================================================
// decode vector positions (also update select codes for samples)
`define FVR_NUM_SAMPLE      6
`define FVR_HIT_W           9
`define FVR_HIT_PHA_V       0
`define FVR_HIT_PHB_V       1
`define FVR_HIT_PHC_V       2
`define FVR_HIT_SIN         3
`define FVR_HIT_COS         4
`define FVR_HIT_STATIONARY_ALPHA_CURRENT      5
`define FVR_HIT_CTRL        6
`define FVR_HIT_STAT        7
`define FVR_HIT_UPD_CNT     8

// ==========================================================
// field positions
`define FVR_CTRL_FREEZE     0
`define FVR_STAT_FRESH_LO   0
`define FVR_STAT_OVR_LO     8
`define FVR_STAT_SIGN_LO    16
`define FVR_STAT_FROZEN     24

// ==========================================================
// reset values
`define FVR_SAMPLE_RST      32'h00000000
`define FVR_WORD_ZERO       32'h00000000
`define FVR_CNT_RST         16'h0000
`define FVR_CNT_ONE         16'h0001

`endif
